// ===== tb.sv
// bench for the waveform timer: apb tasks, duty measurements, interrupt checks
`include "tcwc_params.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [11:0] a_ctl = {4'h0, `TCWC_OFS_CTRL_A};
    localparam logic [11:0] b_ctl = {4'h0, `TCWC_OFS_CTRL_B};
    localparam logic [11:0] a_cmp = {4'h0, `TCWC_OFS_CMP_A};
    localparam logic [11:0] b_cmp = {4'h0, `TCWC_OFS_CMP_B};
    localparam logic [11:0] a_cnt = {4'h0, `TCWC_OFS_COUNT};
    localparam logic [11:0] a_st  = {4'h0, `TCWC_OFS_IRQ_STAT};
    localparam logic [11:0] a_mk  = {4'h0, `TCWC_OFS_IRQ_MASK};
    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        compare_out_a_pin;
    logic        compare_out_a_en;
    logic        compare_out_b_pin;
    logic        compare_out_b_en;
    logic        irq;
    logic        dir_a;
    logic        pad_a;
    logic        pad_b;
    logic [31:0] rd;
    logic        err;
    logic [7:0]  c1;
    int          errors;
    int          total_checks;
    tcwc_timer u_tcwc_timer (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .compare_out_a_pin(compare_out_a_pin),
        .compare_out_a_en(compare_out_a_en), .compare_out_b_pin(compare_out_b_pin),
        .compare_out_b_en(compare_out_b_en), .irq(irq));
    tcwc_pin_model u_tcwc_pin_model (.pin_a(compare_out_a_pin), .en_a(compare_out_a_en),
        .pin_b(compare_out_b_pin), .en_b(compare_out_b_en), .dir_out_a(dir_a),
        .dir_out_b(1'b1), .port_a(1'b0), .port_b(1'b0), .pad_a(pad_a), .pad_b(pad_b));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    task automatic tally_and_finish;
        if (errors == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       input logic [3:0] s);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, 4'h1);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0, 4'h0);
        `CHK(rd, exp)
    endtask
    // stop, load compares in normal mode so they copy at once, then start
    task automatic duty(input logic [7:0] ca, input logic [7:0] cb, input logic [7:0] ma,
                        input logic [7:0] mb, input int settle, input int win,
                        input int ea, input int eb);
        int ha;
        int hb;
        ha = 0;
        hb = 0;
        wr(b_ctl, 32'h0);
        wr(a_ctl, 32'h0);
        wr(a_cmp, {24'h0, ma});
        wr(b_cmp, {24'h0, mb});
        wr(a_ctl, {24'h0, ca});
        wr(b_ctl, {24'h0, cb});
        repeat (settle) @(posedge pclk);
        repeat (win) begin
            @(negedge pclk);
            ha += pad_a;
            hb += pad_b;
        end
        `CHK(ha, ea)
        `CHK(hb, eb)
    endtask
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        pstrb = 4'h0;
        dir_a = 1'b1;
        errors = 0;
        total_checks = 0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        rdc(a_ctl, 32'h0);
        `CHK({compare_out_a_en, compare_out_b_en, irq}, 3'b000)
        wr(a_ctl, 32'hff);
        rdc(a_ctl, 32'hf3);
        apb(1'b1, a_ctl, 32'h00, 4'h0);
        rdc(a_ctl, 32'hf3);
        rdc(12'h0d0, 32'h0);
        `CHK(err, 1'b1)
        duty(8'h70, 8'h01, 8'h02, 8'h03, 1100, 2048, 1024, 2048);
        duty(8'he0, 8'h01, 8'h02, 8'h03, 1100, 1024, 1024, 0);
        duty(8'h42, 8'h01, 8'h1f, 8'h00, 1100, 256, 128, 0);
        duty(8'hb3, 8'h01, 8'h40, 8'h80, 1100, 1024, 260, 508);
        duty(8'h53, 8'h01, 8'h40, 8'h80, 1100, 1024, 0, 0);
        duty(8'h83, 8'h01, 8'hff, 8'h00, 1100, 1024, 1024, 0);
        duty(8'h91, 8'h01, 8'h40, 8'h00, 2100, 2040, 512, 0);
        duty(8'hb1, 8'h01, 8'hff, 8'h80, 2100, 2040, 0, 1016);
        duty(8'h63, 8'h09, 8'h3f, 8'h10, 1100, 512, 256, 136);
        duty(8'h21, 8'h09, 8'h3f, 8'h10, 1100, 504, 0, 128);
        // reserved code 4 must hold the counter
        wr(a_ctl, 32'h0);
        wr(b_ctl, 32'h09);
        apb(1'b0, a_cnt, 32'h0, 4'h0);
        c1 = rd[7:0];
        repeat (40) @(posedge pclk);
        rdc(a_cnt, {24'h0, c1});
        wr(b_ctl, 32'h01);
        wr(a_mk, 32'h1);
        for (int n = 0; n < 1100 && irq !== 1'b1; n++) @(posedge pclk);
        `CHK(irq, 1'b1)
        apb(1'b0, a_st, 32'h0, 4'h0);
        `CHK(rd[0], 1'b1)
        apb(1'b0, a_st, 32'h0, 4'h0);
        `CHK(rd[0], 1'b0)
        `CHK(irq, 1'b0)
        wr(a_mk, 32'h0);
        repeat (1100) @(posedge pclk);
        `CHK(irq, 1'b0)
        apb(1'b0, a_st, 32'h0, 4'h0);
        `CHK(rd[0], 1'b1)
        dir_a <= 1'b0;
        @(posedge pclk);
        #1 `CHK(pad_a, 1'b1)
        tally_and_finish;
    end
    initial begin
        repeat (60000) @(posedge pclk);
        errors++;
        tally_and_finish;
    end
endmodule
bind tcwc_timer tcwc_timer_assertions u_tcwc_timer_assertions (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .compare_out_a_pin(compare_out_a_pin), .compare_out_a_en(compare_out_a_en),
    .compare_out_b_pin(compare_out_b_pin), .compare_out_b_en(compare_out_b_en), .irq(irq));

// ===== tcwc_params.svh
// register offsets, field positions, reset values and timing counts
`ifndef TCWC_PARAMS_SVH
`define TCWC_PARAMS_SVH

`define TCWC_ADDR_W          8
`define TCWC_OFS_CTRL_A      8'hb0
`define TCWC_OFS_CTRL_B      8'hb4
`define TCWC_OFS_CMP_A       8'hb8
`define TCWC_OFS_CMP_B       8'hbc
`define TCWC_OFS_COUNT       8'hc0
`define TCWC_OFS_IRQ_STAT    8'hc4
`define TCWC_OFS_IRQ_MASK    8'hc8

`define TCWC_CTRL_A_RESET    8'h00
`define TCWC_CTRL_A_WMASK    8'hf3
`define TCWC_CTRL_B_RESET    8'h00
`define TCWC_CTRL_B_WMASK    8'h09
`define TCWC_CMP_RESET       8'h00

`define TCWC_F_MODE_A_HI     7
`define TCWC_F_MODE_A_LO     6
`define TCWC_F_MODE_B_HI     5
`define TCWC_F_MODE_B_LO     4
`define TCWC_F_WGM_LO_HI     1
`define TCWC_F_WGM_LO_LO     0
`define TCWC_F_WGM_HI        3
`define TCWC_F_RUN           0

`define TCWC_IRQ_OVF         0
`define TCWC_IRQ_MATCH_A     1
`define TCWC_IRQ_MATCH_B     2

`define TCWC_MAX             8'hff
`define TCWC_BOTTOM          8'h00
`define TCWC_TICK_DIV        4'h4

`endif

// ===== tcwc_pin_model.sv
// far side of the compare outputs: two pads with port fallback and pull-ups
module tcwc_pin_model (
    // from the timer
    input  wire logic pin_a,
    input  wire logic en_a,
    input  wire logic pin_b,
    input  wire logic en_b,
    // port setup made by software
    input  wire logic dir_out_a,
    input  wire logic dir_out_b,
    input  wire logic port_a,
    input  wire logic port_b,
    // resolved pad levels
    output logic      pad_a,
    output logic      pad_b
);
    // without the direction bit no driver reaches the pad, the pull-up wins
    assign pad_a = !dir_out_a ? 1'b1 : (en_a ? pin_a : port_a);
    assign pad_b = !dir_out_b ? 1'b1 : (en_b ? pin_b : port_b);
endmodule

// ===== tcwc_pkg.sv
// types shared by the waveform control block
package tcwc_pkg;

    typedef logic [7:0] tcwc_byte_t;
    typedef logic [1:0] tcwc_out_mode_t;

    typedef enum logic [4:0] {
        TCWC_FAM_NORMAL = 5'b00001,
        TCWC_FAM_CTC    = 5'b00010,
        TCWC_FAM_FAST   = 5'b00100,
        TCWC_FAM_PHASE  = 5'b01000,
        TCWC_FAM_RSVD   = 5'b10000
    } tcwc_family_t;

endpackage

// ===== tcwc_timer.sv
// 8-bit timer with waveform generation modes, compare outputs and apb registers
// Operation
// - nonzero output-mode field hands the pin to the compare output, except pwm code one unless channel a with wgm_hi set
// - non-pwm codes: off, toggle, clear, set on compare match
// - fast pwm channel a: code two clear/set-bottom, three the inverse
// - pwm channel a code one: off if wgm_hi clear, else toggle
// - fast pwm channel b: code one reserved, two and three as channel a
// - fast pwm compare at top with high bit: act only at bottom
// - phase pwm channel a: code two clears up, sets down; three reverse
// - phase pwm channel b: code one reserved, two and three as a
// - phase pwm compare at top with high bit: act only at top
// - control bits 3 and 2 always read zero
// - mode is three bits: two here, one in the second control
// - mode table selects count sequence, top source and waveform
// - compare reload and overflow point follow the mode
//
// The APB interface to the registers was left to the implementer.
`include "tcwc_params.svh"

module tcwc_timer (
    // clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    // compare output pins
    output logic             compare_out_a_pin,
    output logic             compare_out_a_en,
    output logic             compare_out_b_pin,
    output logic             compare_out_b_en,
    // interrupt
    output logic             irq
);
    import tcwc_pkg::*;

    // registers
    tcwc_byte_t   waveform_control_a_q;
    tcwc_byte_t   waveform_control_b_q;
    tcwc_byte_t   cmp_buf_a_q;
    tcwc_byte_t   cmp_buf_b_q;
    tcwc_byte_t   compare_value_a_q;
    tcwc_byte_t   compare_value_b_q;
    tcwc_byte_t   count_q;
    tcwc_byte_t   count_d;
    logic         count_down_q;
    logic [3:0]   div_q;
    logic         tick;
    logic [2:0]   irq_stat_q;
    logic [2:0]   irq_mask_q;
    logic [2:0]   irq_event;
    logic [31:0]  prdata_q;

    // decoded mode
    logic [2:0]     wave_gen_mode;
    tcwc_family_t   family;
    tcwc_byte_t     top_value;
    logic           top_from_compare_a;
    tcwc_out_mode_t cmp_out_mode_a;
    tcwc_out_mode_t cmp_out_mode_b;
    logic           at_top;
    logic           at_bottom;
    logic           to_bottom;
    logic           match_a;
    logic           match_b;
    logic           overflow_flag;

    // bus decode
    logic         acc_setup;
    logic         acc_write;
    logic         acc_read;
    logic         addr_ok;
    logic [7:0]   addr_lo;

    // codes 4 and 6 are reserved
    function automatic tcwc_family_t mode_family(input logic [2:0] m);
        unique case (m)
            3'h0:    mode_family = TCWC_FAM_NORMAL;
            3'h1:    mode_family = TCWC_FAM_PHASE;
            3'h2:    mode_family = TCWC_FAM_CTC;
            3'h3:    mode_family = TCWC_FAM_FAST;
            3'h5:    mode_family = TCWC_FAM_PHASE;
            3'h7:    mode_family = TCWC_FAM_FAST;
            default: mode_family = TCWC_FAM_RSVD;
        endcase
    endfunction

    // anything else gets pslverr
    function automatic logic is_mapped(input logic [11:0] a);
        is_mapped = (a[11:8] == 4'h0) && (
            a[7:0] == `TCWC_OFS_CTRL_A || a[7:0] == `TCWC_OFS_CTRL_B ||
            a[7:0] == `TCWC_OFS_CMP_A || a[7:0] == `TCWC_OFS_CMP_B ||
            a[7:0] == `TCWC_OFS_COUNT || a[7:0] == `TCWC_OFS_IRQ_STAT ||
            a[7:0] == `TCWC_OFS_IRQ_MASK);
    endfunction

    // mode field spans both control registers
    assign wave_gen_mode = {waveform_control_b_q[`TCWC_F_WGM_HI],
                            waveform_control_a_q[`TCWC_F_WGM_LO_HI:`TCWC_F_WGM_LO_LO]};
    // family picks wave and count
    assign family = mode_family(wave_gen_mode);
    assign top_from_compare_a = (wave_gen_mode == 3'h2) || (wave_gen_mode == 3'h5) ||
                                (wave_gen_mode == 3'h7);
    assign top_value = top_from_compare_a ? compare_value_a_q : `TCWC_MAX;

    // output-mode fields of ctrl a
    assign cmp_out_mode_a = waveform_control_a_q[`TCWC_F_MODE_A_HI:`TCWC_F_MODE_A_LO];
    assign cmp_out_mode_b = waveform_control_a_q[`TCWC_F_MODE_B_HI:`TCWC_F_MODE_B_LO];

    // timer tick: one-cycle enable from the divider, gated by run
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_q <= 4'h0;
        end else if (!waveform_control_b_q[`TCWC_F_RUN]) begin
            div_q <= 4'h0;
        end else if (div_q == `TCWC_TICK_DIV - 4'h1) begin
            div_q <= 4'h0;
        end else begin
            div_q <= div_q + 4'h1;
        end
    end

    // reserved modes freeze the counter rather than run an undefined sequence
    assign tick = waveform_control_b_q[`TCWC_F_RUN] &&
                  (div_q == `TCWC_TICK_DIV - 4'h1) && (family != TCWC_FAM_RSVD);

    // top is compare a in 2, 5, 7
    assign at_top    = (count_q == top_value);
    assign at_bottom = (count_q == `TCWC_BOTTOM);
    // flags the fast pwm wrap from top to bottom; ctc also wraps, but only in the count logic
    assign to_bottom = at_top && (family == TCWC_FAM_FAST);
    // matches count on a tick only
    assign match_a   = tick && (count_q == compare_value_a_q);
    assign match_b   = tick && (count_q == compare_value_b_q);

    // count sequence per mode
    always_comb begin
        count_d = count_q;
        if (tick) begin
            unique case (family)
                TCWC_FAM_NORMAL: count_d = count_q + 8'h01;
                TCWC_FAM_CTC, TCWC_FAM_FAST: begin
                    count_d = at_top ? `TCWC_BOTTOM : count_q + 8'h01;
                end
                TCWC_FAM_PHASE: begin
                    if (count_down_q) begin
                        count_d = at_bottom ? count_q + 8'h01 : count_q - 8'h01;
                    end else begin
                        count_d = at_top ? count_q - 8'h01 : count_q + 8'h01;
                    end
                end
                TCWC_FAM_RSVD: count_d = count_q;
            endcase
        end
    end

    // counter survives mode changes
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= `TCWC_BOTTOM;
        end else begin
            count_q <= count_d;
        end
    end

    // direction: phase modes only
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_down_q <= 1'b0;
        end else if (family != TCWC_FAM_PHASE) begin
            count_down_q <= 1'b0;
        end else if (tick && at_top && !count_down_q) begin
            count_down_q <= 1'b1;
        end else if (tick && at_bottom && count_down_q) begin
            count_down_q <= 1'b0;
        end
    end

    // compare reload: immediate, at top, or at bottom by mode
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_a_q <= `TCWC_CMP_RESET;
            compare_value_b_q <= `TCWC_CMP_RESET;
        end else begin
            unique case (family)
                TCWC_FAM_NORMAL, TCWC_FAM_CTC, TCWC_FAM_RSVD: begin
                    compare_value_a_q <= cmp_buf_a_q;
                    compare_value_b_q <= cmp_buf_b_q;
                end
                TCWC_FAM_PHASE: begin
                    if (tick && at_top) begin
                        compare_value_a_q <= cmp_buf_a_q;
                        compare_value_b_q <= cmp_buf_b_q;
                    end
                end
                TCWC_FAM_FAST: begin
                    if (tick && to_bottom) begin
                        compare_value_a_q <= cmp_buf_a_q;
                        compare_value_b_q <= cmp_buf_b_q;
                    end
                end
            endcase
        end
    end

    // overflow point by mode
    always_comb begin
        unique case (wave_gen_mode)
            3'h0, 3'h2, 3'h3: overflow_flag = tick && (count_q == `TCWC_MAX);
            3'h1, 3'h5:       overflow_flag = tick && at_bottom;
            3'h7:             overflow_flag = tick && at_top;
            default:          overflow_flag = 1'b0;
        endcase
    end

    // channels share counter, tick
    tcwc_wave_chan u_chan_a (
        .pclk       (pclk),
        .presetn    (presetn),
        .is_chan_a  (1'b1),
        .family     (family),
        .out_mode   (cmp_out_mode_a),
        .wgm_hi     (wave_gen_mode[2]),
        .tick       (tick),
        .match      (match_a),
        .cmp_is_top (compare_value_a_q == top_value),
        .at_top     (at_top),
        .to_bottom  (to_bottom),
        .count_down (count_down_q),
        .pin_q      (compare_out_a_pin),
        .pin_en     (compare_out_a_en)
    );

    // b: code one off in pwm
    tcwc_wave_chan u_chan_b (
        .pclk       (pclk),
        .presetn    (presetn),
        .is_chan_a  (1'b0),
        .family     (family),
        .out_mode   (cmp_out_mode_b),
        .wgm_hi     (wave_gen_mode[2]),
        .tick       (tick),
        .match      (match_b),
        .cmp_is_top (compare_value_b_q == top_value),
        .at_top     (at_top),
        .to_bottom  (to_bottom),
        .count_down (count_down_q),
        .pin_q      (compare_out_b_pin),
        .pin_en     (compare_out_b_en)
    );

    // apb: zero wait states, read data captured in the setup cycle
    assign addr_lo   = paddr[7:0];
    assign addr_ok   = is_mapped(paddr);
    assign acc_setup = psel && !penable;
    assign acc_write = psel && penable && pwrite && addr_ok;
    assign acc_read  = psel && penable && !pwrite && addr_ok;
    assign pready    = 1'b1;
    assign pslverr   = psel && penable && !addr_ok;
    assign prdata    = prdata_q;

    // setup capture: no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 32'h0000_0000;
        end else if (acc_setup && !pwrite) begin
            prdata_q <= 32'h0000_0000;
            if (paddr[11:8] == 4'h0) begin
                unique case (addr_lo)
                    `TCWC_OFS_CTRL_A:   prdata_q[7:0] <= waveform_control_a_q;
                    `TCWC_OFS_CTRL_B:   prdata_q[7:0] <= waveform_control_b_q;
                    `TCWC_OFS_CMP_A:    prdata_q[7:0] <= cmp_buf_a_q;
                    `TCWC_OFS_CMP_B:    prdata_q[7:0] <= cmp_buf_b_q;
                    `TCWC_OFS_COUNT:    prdata_q[7:0] <= count_q;
                    `TCWC_OFS_IRQ_STAT: prdata_q[2:0] <= irq_stat_q;
                    `TCWC_OFS_IRQ_MASK: prdata_q[2:0] <= irq_mask_q;
                    default:            prdata_q      <= 32'h0000_0000;
                endcase
            end
        end
    end

    // control registers; reserved bits are never stored
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            waveform_control_a_q <= `TCWC_CTRL_A_RESET;
            waveform_control_b_q <= `TCWC_CTRL_B_RESET;
        end else if (acc_write && pstrb[0]) begin
            if (addr_lo == `TCWC_OFS_CTRL_A) begin
                waveform_control_a_q <= pwdata[7:0] & `TCWC_CTRL_A_WMASK;
            end
            if (addr_lo == `TCWC_OFS_CTRL_B) begin
                waveform_control_b_q <= pwdata[7:0] & `TCWC_CTRL_B_WMASK;
            end
        end
    end

    // writes go to reload buffers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_buf_a_q <= `TCWC_CMP_RESET;
            cmp_buf_b_q <= `TCWC_CMP_RESET;
            irq_mask_q  <= 3'h0;
        end else if (acc_write && pstrb[0]) begin
            if (addr_lo == `TCWC_OFS_CMP_A) begin
                cmp_buf_a_q <= pwdata[7:0];
            end
            if (addr_lo == `TCWC_OFS_CMP_B) begin
                cmp_buf_b_q <= pwdata[7:0];
            end
            if (addr_lo == `TCWC_OFS_IRQ_MASK) begin
                irq_mask_q <= pwdata[2:0];
            end
        end
    end

    // sticky status, read clears; a new event in the same cycle survives
    assign irq_event[`TCWC_IRQ_OVF]     = overflow_flag;
    assign irq_event[`TCWC_IRQ_MATCH_A] = match_a;
    assign irq_event[`TCWC_IRQ_MATCH_B] = match_b;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_q <= 3'h0;
        end else if (acc_read && addr_lo == `TCWC_OFS_IRQ_STAT) begin
            irq_stat_q <= irq_event;
        end else begin
            irq_stat_q <= irq_stat_q | irq_event;
        end
    end

    // level until status is read
    assign irq = |(irq_stat_q & irq_mask_q);

endmodule

// ===== tcwc_timer_assertions.sv
// concurrent checks on the ports of the waveform timer
`include "tcwc_params.svh"
module tcwc_timer_assertions (
    // clock and reset
    input wire logic        pclk,
    input wire logic        presetn,
    // apb
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // pins and interrupt
    input wire logic        compare_out_a_pin,
    input wire logic        compare_out_a_en,
    input wire logic        compare_out_b_pin,
    input wire logic        compare_out_b_en,
    input wire logic        irq
);
    localparam logic [11:0] ctl_a_adr = {4'h0, `TCWC_OFS_CTRL_A};
    localparam logic [11:0] ctl_b_adr = {4'h0, `TCWC_OFS_CTRL_B};
    localparam logic [11:0] mask_adr  = {4'h0, `TCWC_OFS_IRQ_MASK};
    logic       acc;
    logic       wr0;
    logic       mapped;
    logic       pwm;
    logic       rsvd;
    logic [7:0] ctl_a_q;
    logic [7:0] ctl_b_q;
    assign acc = psel && penable;
    assign wr0 = acc && pwrite && pstrb[0];
    assign mapped = paddr[11:8] == 4'h0 && paddr[1:0] == 2'h0
                    && paddr[7:0] >= `TCWC_OFS_CTRL_A && paddr[7:0] <= `TCWC_OFS_IRQ_MASK;
    assign pwm = ctl_a_q[0];
    assign rsvd = ctl_b_q[3] && !ctl_a_q[0];
    // shadows of the control bytes, so pin ownership can be predicted
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_a_q <= 8'h00;
        end else if (wr0 && paddr == ctl_a_adr) begin
            ctl_a_q <= pwdata[7:0] & `TCWC_CTRL_A_WMASK;
        end
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctl_b_q <= 8'h00;
        end else if (wr0 && paddr == ctl_b_adr) begin
            ctl_b_q <= pwdata[7:0] & `TCWC_CTRL_B_WMASK;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    pins_released_a: assert property ($rose(presetn)
        |-> !compare_out_a_en && !compare_out_b_en) else $error("pin owned right after reset");
    own_pin_a_a: assert property (!rsvd |-> compare_out_a_en ==
        (ctl_a_q[7:6] != 2'h0 && !(ctl_a_q[7:6] == 2'h1 && pwm && !ctl_b_q[3])))
        else $error("channel a ownership wrong");
    own_pin_b_a: assert property (!rsvd |-> compare_out_b_en ==
        (ctl_a_q[5:4] != 2'h0 && !(ctl_a_q[5:4] == 2'h1 && pwm)))
        else $error("channel b ownership wrong");
    rsvd_zero_a: assert property (acc && !pwrite && paddr == ctl_a_adr
        |-> prdata[3:2] == 2'h0 && prdata[31:8] == 24'h0) else $error("reserved bits not zero");
    ctrl_echo_a: assert property (acc && !pwrite && paddr == ctl_a_adr
        |-> prdata[7:0] == ctl_a_q) else $error("control readback differs");
    frozen_pins_a: assert property ((!ctl_b_q[0] || rsvd) [*2]
        |=> $stable(compare_out_a_pin) && $stable(compare_out_b_pin))
        else $error("pin moved idle");
    tick_gap_a: assert property ($changed(compare_out_a_pin)
        |=> $stable(compare_out_a_pin) [*3]) else $error("pin a moved between ticks");
    mask_off_a: assert property (wr0 && paddr == mask_adr && pwdata[2:0] == 3'h0
        |=> !irq) else $error("irq with all masked");
    unmapped_err_a: assert property (acc && !mapped |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    mapped_ok_a: assert property (acc && mapped |-> !pslverr && pready)
        else $error("mapped access refused");
    cover property (compare_out_a_en && $rose(compare_out_a_pin));
    cover property ($rose(irq));
    cover property (acc && pslverr);
endmodule

// ===== tcwc_wave_chan.sv
// one compare output channel: pin level and pin override enable
module tcwc_wave_chan (
    // clock and reset
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    // configuration
    input  wire logic                   is_chan_a,
    input  wire tcwc_pkg::tcwc_family_t family,
    input  wire tcwc_pkg::tcwc_out_mode_t out_mode,
    input  wire logic                   wgm_hi,
    // counter events; only match arrives qualified by the timer tick, the others are levels
    input  wire logic                   tick,
    input  wire logic                   match,
    input  wire logic                   cmp_is_top,
    input  wire logic                   at_top,
    input  wire logic                   to_bottom,
    input  wire logic                   count_down,
    // pin side
    output logic                        pin_q,
    output logic                        pin_en
);
    import tcwc_pkg::*;

    logic pwm;
    logic code1_live;
    logic special;
    logic pin_d;

    assign pwm = (family == TCWC_FAM_FAST) || (family == TCWC_FAM_PHASE);
    // code one in pwm: only channel a with wgm_hi toggles, else disconnected
    assign code1_live = is_chan_a && wgm_hi;
    // compare at top with high mode bit: match ignored in pwm
    assign special = pwm && cmp_is_top && out_mode[1];

    always_comb begin
        if (out_mode == 2'b00) begin
            pin_en = 1'b0;
        end else if (pwm && out_mode == 2'b01) begin
            pin_en = code1_live;
        end else begin
            pin_en = 1'b1;
        end
    end

    always_comb begin
        pin_d = pin_q;
        if (tick) begin
            unique case (family)
                TCWC_FAM_NORMAL, TCWC_FAM_CTC: begin
                    if (match) begin
                        unique case (out_mode)
                            2'b01:   pin_d = ~pin_q;
                            2'b10:   pin_d = 1'b0;
                            2'b11:   pin_d = 1'b1;
                            default: pin_d = pin_q;
                        endcase
                    end
                end
                TCWC_FAM_FAST: begin
                    if (out_mode[1]) begin
                        if (match && !special) begin
                            pin_d = out_mode[0];
                        end else if (to_bottom) begin
                            pin_d = ~out_mode[0];
                        end
                    end else if (out_mode[0] && code1_live && match) begin
                        pin_d = ~pin_q;
                    end
                end
                TCWC_FAM_PHASE: begin
                    if (out_mode[1]) begin
                        if (special) begin
                            if (at_top) begin
                                pin_d = out_mode[0];
                            end
                        end else if (match) begin
                            pin_d = count_down ? ~out_mode[0] : out_mode[0];
                        end
                    end else if (out_mode[0] && code1_live && match) begin
                        pin_d = ~pin_q;
                    end
                end
                TCWC_FAM_RSVD: pin_d = pin_q;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_q <= 1'b0;
        end else begin
            pin_q <= pin_d;
        end
    end

endmodule
